// File: hw/qt_pkg.sv
package qt_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_TIMERS = 4;
	localparam int CNT_W      = 32;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [1:0] TIMER_AREA  = 2'h0;  // addr[7:6] of the per-timer slots
	localparam logic [3:0] OFF_LOAD    = 4'h0;  // offset inside a 16-byte timer slot
	localparam logic [3:0] OFF_VALUE   = 4'h4;
	localparam logic [3:0] OFF_CTRL    = 4'h8;
	localparam logic [7:0] ADDR_STATUS = 8'h40;
	localparam logic [7:0] ADDR_MASK   = 8'h44;

	// ----------------------------------------------------------------
	// prescale encodings and divider limits
	// ----------------------------------------------------------------
	localparam logic [1:0] PRE_DIV1    = 2'h0;
	localparam logic [1:0] PRE_DIV16   = 2'h1;
	localparam logic [1:0] PRE_DIV256  = 2'h2;
	localparam logic [7:0] DIV16_LAST  = 8'h0F;
	localparam logic [7:0] DIV256_LAST = 8'hFF;
	localparam logic [7:0] PRESC_RST   = 8'h00;

	// ----------------------------------------------------------------
	// values after reset and counter limits
	// ----------------------------------------------------------------
	localparam logic [31:0] LOAD_RST   = 32'h00000000;
	localparam logic [31:0] COUNT_RST  = 32'h00000000;
	localparam logic [31:0] COUNT_MAX  = 32'hFFFFFFFF;
	localparam logic [31:0] COUNT_ONE  = 32'h00000001;
	localparam logic [3:0]  MASK_RST   = 4'h0;
	localparam logic [3:0]  STATUS_RST = 4'h0;

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-timer control word, low nibble of the control register
	typedef struct packed
	{
		logic [1:0] prescale;  // bits 3:2
		logic       periodic;  // bit 1, 0 = free running
		logic       enable;    // bit 0
	} ctrl_t;

	localparam ctrl_t CTRL_RST = '{prescale: 2'h0, periodic: 1'b0, enable: 1'b0};

	// merge write data into an old word under byte strobes
	function automatic logic [31:0] mergeBytes(input logic [31:0] oldWord,
		input logic [31:0] newWord, input logic [3:0] strb);
		logic [31:0] res;
		res = oldWord;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = newWord[b*8 +: 8];
		end
		return res;
	endfunction

endpackage

// File: hw/timer_channel.sv
`timescale 1ns/1ns
module timer_channel
(
	input  wire logic         sys_clk,     // module clock
	input  wire logic         rst_n,       // async reset, active low
	input  qt_pkg::ctrl_t     cfg,         // enable, mode, prescale
	input  wire logic         loadWr,      // one-cycle restart pulse
	input  wire logic [31:0]  reloadValue, // load register contents
	output logic [31:0]       count,       // current count
	output logic              tick,        // prescaled tick this cycle
	output logic              zeroEvt      // pulse: count just reached zero
);

	logic [7:0]  presc;
	logic [31:0] next_count;
	logic        divHit;

	// ----------------------------------------------------------------
	// prescaler
	// ----------------------------------------------------------------
	// the reserved prescale code behaves as divide by 256
	assign divHit = (cfg.prescale == qt_pkg::PRE_DIV16) ? (presc[3:0] == qt_pkg::DIV16_LAST[3:0])
		: (presc == qt_pkg::DIV256_LAST);
	assign tick = cfg.enable && !loadWr && ((cfg.prescale == qt_pkg::PRE_DIV1) || divHit);

	// prescaler restarts with the counter so the first period after a load is whole
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			presc <= qt_pkg::PRESC_RST;
		else if (loadWr)
			presc <= qt_pkg::PRESC_RST;
		else if (cfg.enable)
			presc <= presc + 8'h01;
	end

	// ----------------------------------------------------------------
	// down counter
	// ----------------------------------------------------------------
	// a load wins over a tick; zero wraps or reloads on the next tick
	assign next_count = loadWr ? reloadValue
		: !tick ? count
		: (count != qt_pkg::COUNT_RST) ? count - qt_pkg::COUNT_ONE
		: cfg.periodic ? reloadValue
		: qt_pkg::COUNT_MAX;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= qt_pkg::COUNT_RST;
		else
			count <= next_count;
	end

	// event flagged in the same cycle the count shows zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			zeroEvt <= 1'b0;
		else
			zeroEvt <= tick && (count == qt_pkg::COUNT_ONE);
	end

endmodule

// File: hw/quad_timer.sv
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ns
module quad_timer
(
	input  wire logic         sys_clk, // module clock, 50 MHz
	input  wire logic         rst_n,   // async reset, active low
	input  wire logic [7:0]   awaddr,  // write address
	input  wire logic         awvalid, // write address valid
	output logic              awready, // write address ready
	input  wire logic [31:0]  wdata,   // write data
	input  wire logic [3:0]   wstrb,   // write byte strobes
	input  wire logic         wvalid,  // write data valid
	output logic              wready,  // write data ready
	output logic [1:0]        bresp,   // write response
	output logic              bvalid,  // write response valid
	input  wire logic         bready,  // write response ready
	input  wire logic [7:0]   araddr,  // read address
	input  wire logic         arvalid, // read address valid
	output logic              arready, // read address ready
	output logic [31:0]       rdata,   // read data
	output logic [1:0]        rresp,   // read response
	output logic              rvalid,  // read data valid
	input  wire logic         rready,  // read data ready
	output logic              irq      // level interrupt, high while unmasked flag set
);

	localparam int NT = qt_pkg::NUM_TIMERS;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [31:0]   loadReg  [NT];
	qt_pkg::ctrl_t ctrlReg  [NT];
	logic [31:0]   countVal [NT];
	logic [NT-1:0] tick;
	logic [NT-1:0] zeroEvt;
	logic [NT-1:0] loadWr;
	logic [NT-1:0] status;
	logic [NT-1:0] mask;
	logic [NT-1:0] next_status;

	// write channel holding registers
	logic          awHeld;
	logic          wHeld;
	logic [7:0]    awAddrQ;
	logic [31:0]   wDataQ;
	logic [3:0]    wStrbQ;

	// write decode
	logic          doWrite;
	logic          wrInTimer;
	logic [1:0]    wrIdx;
	logic [3:0]    wrOff;
	logic [NT-1:0] wrLoadHit;
	logic [NT-1:0] wrCtrlHit;
	logic          wrStatusHit;
	logic          wrMaskHit;
	logic          wrOk;
	logic [NT-1:0] statusClr;

	// read decode
	logic          rdInTimer;
	logic [1:0]    rdIdx;
	logic [3:0]    rdOff;
	logic [31:0]   rdWord;
	logic          rdOk;

	// every check in this module runs on the module clock and sleeps in reset
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// write address and data channels
	// ----------------------------------------------------------------
	// each channel is held until both are in; no new pair while a response waits
	assign awready = !awHeld && !bvalid;
	assign wready  = !wHeld && !bvalid;
	assign doWrite = awHeld && wHeld && !bvalid;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			awHeld <= 1'b0;
		else if (awvalid && awready)
			awHeld <= 1'b1;
		else if (doWrite)
			awHeld <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wHeld <= 1'b0;
		else if (wvalid && wready)
			wHeld <= 1'b1;
		else if (doWrite)
			wHeld <= 1'b0;
	end

	// payload capture
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awAddrQ <= 8'h00;
			wDataQ  <= 32'h00000000;
			wStrbQ  <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
				awAddrQ <= awaddr;
			if (wvalid && wready)
			begin
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
		end
	end

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	assign wrInTimer   = (awAddrQ[7:6] == qt_pkg::TIMER_AREA);
	assign wrIdx       = awAddrQ[5:4];
	assign wrOff       = {awAddrQ[3:2], 2'h0};
	assign wrStatusHit = doWrite && (awAddrQ == qt_pkg::ADDR_STATUS);
	assign wrMaskHit   = doWrite && (awAddrQ == qt_pkg::ADDR_MASK);
	assign wrOk        = (|wrLoadHit) || (|wrCtrlHit) || wrStatusHit || wrMaskHit;
	assign statusClr   = wrStatusHit && wStrbQ[0] ? wDataQ[NT-1:0] : '0;

	// write response; the count register is read only and answers an error
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bvalid <= 1'b0;
			bresp  <= qt_pkg::RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp  <= wrOk ? qt_pkg::RESP_OKAY : qt_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// timer instances
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NT; i++)
	begin : g_timer
		assign wrLoadHit[i] = doWrite && wrInTimer && (wrIdx == 2'(i)) && (wrOff == qt_pkg::OFF_LOAD);
		assign wrCtrlHit[i] = doWrite && wrInTimer && (wrIdx == 2'(i)) && (wrOff == qt_pkg::OFF_CTRL);

		// each instance sees only its own slot of the register file
		timer_channel u_chan
		(
			.sys_clk     (sys_clk),
			.rst_n       (rst_n),
			.cfg         (ctrlReg[i]),
			.loadWr      (loadWr[i]),
			.reloadValue (loadReg[i]),
			.count       (countVal[i]),
			.tick        (tick[i]),
			.zeroEvt     (zeroEvt[i])
		);

		sequence s_reach_zero;
			tick[i] && countVal[i] == qt_pkg::COUNT_ONE;
		endsequence

		sequence s_at_zero;
			tick[i] && countVal[i] == qt_pkg::COUNT_RST;
		endsequence

		property p_zero_flag;
			s_reach_zero |=> (zeroEvt[i] && countVal[i] == qt_pkg::COUNT_RST) ##1 status[i];
		endproperty

		a_zero_flag: assert property (p_zero_flag)
			else $error("zero reached without flag");
		a_count_dec: assert property (tick[i] && countVal[i] != qt_pkg::COUNT_RST
			|=> countVal[i] == $past(countVal[i]) - qt_pkg::COUNT_ONE)
			else $error("counter did not step down by one");
		a_free_wrap: assert property (s_at_zero and !ctrlReg[i].periodic
			|=> countVal[i] == qt_pkg::COUNT_MAX)
			else $error("free running counter did not wrap");
		a_period_reload: assert property (s_at_zero and ctrlReg[i].periodic
			|=> countVal[i] == $past(loadReg[i]))
			else $error("periodic counter did not reload");
		a_load_restart: assert property (wrLoadHit[i]
			|=> ##1 countVal[i] == $past(loadReg[i]))
			else $error("load write did not restart counter");
		a_idle_hold: assert property (!ctrlReg[i].enable && !loadWr[i]
			|=> countVal[i] == $past(countVal[i]))
			else $error("disabled counter moved");
		a_div16_gap: assert property (tick[i] && ctrlReg[i].prescale == qt_pkg::PRE_DIV16
			|=> (!tick[i] || ctrlReg[i].prescale != qt_pkg::PRE_DIV16) [*8])
			else $error("divide by 16 ticked too early");
		a_flag_sticky: assert property (status[i] && !statusClr[i] |=> status[i])
			else $error("interrupt flag dropped without clear");
	end

	// ----------------------------------------------------------------
	// register file writes
	// ----------------------------------------------------------------
	// the load pulse trails the register update by one cycle so the channel
	// restarts from the merged value, not the old one
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < NT; k++)
			begin
				loadReg[k] <= qt_pkg::LOAD_RST;
				ctrlReg[k] <= qt_pkg::CTRL_RST;
			end
			loadWr <= '0;
		end
		else
		begin
			for (int k = 0; k < NT; k++)
			begin
				if (wrLoadHit[k])
					loadReg[k] <= qt_pkg::mergeBytes(loadReg[k], wDataQ, wStrbQ);
				if (wrCtrlHit[k] && wStrbQ[0])
					ctrlReg[k] <= qt_pkg::ctrl_t'(wDataQ[3:0]);
			end
			loadWr <= wrLoadHit;
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags and mask
	// ----------------------------------------------------------------
	// a zero event in the clearing cycle keeps its flag set
	assign next_status = (status & ~statusClr) | zeroEvt;
	assign irq         = |(status & mask);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status <= qt_pkg::STATUS_RST;
			mask   <= qt_pkg::MASK_RST;
		end
		else
		begin
			status <= next_status;
			if (wrMaskHit && wStrbQ[0])
				mask <= wDataQ[NT-1:0];
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign arready   = !rvalid;
	assign rdInTimer = (araddr[7:6] == qt_pkg::TIMER_AREA);
	assign rdIdx     = araddr[5:4];
	assign rdOff     = {araddr[3:2], 2'h0};

	// read select; the count is sampled, so reading never disturbs it
	always_comb
	begin
		rdWord = 32'h00000000;
		rdOk   = 1'b1;
		if (rdInTimer && rdOff == qt_pkg::OFF_LOAD)
			rdWord = loadReg[rdIdx];
		else if (rdInTimer && rdOff == qt_pkg::OFF_VALUE)
			rdWord = countVal[rdIdx];
		else if (rdInTimer && rdOff == qt_pkg::OFF_CTRL)
			rdWord = {28'h0000000, ctrlReg[rdIdx]};
		else if (araddr == qt_pkg::ADDR_STATUS)
			rdWord = {28'h0000000, status};
		else if (araddr == qt_pkg::ADDR_MASK)
			rdWord = {28'h0000000, mask};
		else
			rdOk = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= qt_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= rdWord;
			rresp  <= rdOk ? qt_pkg::RESP_OKAY : qt_pkg::RESP_SLVERR;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// bus checks
	// ----------------------------------------------------------------
	a_read_count: assert property (arvalid && arready
		&& araddr == {qt_pkg::TIMER_AREA, 2'h0, qt_pkg::OFF_VALUE}
		|=> rvalid && rdata == $past(countVal[0]))
		else $error("count read returned wrong value");
	a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");

endmodule

// File: testbench/quad_down_counter_timer_tb_top.sv
`timescale 1ns/1ns
module quad_down_counter_timer_tb_top;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	typedef struct packed
	{
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] re;
		logic [1:0]  be;
		logic [1:0]  rr;
	} row_t;
	localparam logic [1:0] OK = qt_pkg::RESP_OKAY;
	localparam logic [1:0] ER = qt_pkg::RESP_SLVERR;
	logic        sys_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hF;
	logic        wvalid  = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready  = 1'b0;
	logic        irq;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          acc;   // edge at which the last read address was taken
	int          a1;
	int          div [3] = '{1, 16, 256};
	logic [1:0]  pre [3] = '{qt_pkg::PRE_DIV1, qt_pkg::PRE_DIV16, qt_pkg::PRE_DIV256};
	logic [31:0] c1;
	logic [31:0] c2;
	logic [1:0]  rs;
	row_t        rows [7] = '{
		'{8'h00, 32'h12345678, 8'h04, 32'h12345678, OK, OK},
		'{8'h10, 32'hCAFE0001, 8'h10, 32'hCAFE0001, OK, OK},
		'{8'h14, 32'h00000000, 8'h14, 32'hCAFE0001, ER, OK},
		'{8'h18, 32'hFFFFFFF6, 8'h18, 32'h00000006, OK, OK},
		'{8'h44, 32'hFFFFFFFA, 8'h44, 32'h0000000A, OK, OK},
		'{8'h0C, 32'h00000001, 8'h0C, 32'h00000000, ER, ER},
		'{8'h48, 32'h00000001, 8'h40, 32'h00000000, ER, OK}};

	// clock and a free cycle count used to measure spans between reads
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	quad_timer dut
	(
		.sys_clk(sys_clk), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.irq(irq)
	);

	// ------------------------------------------------
	// reporting
	// ------------------------------------------------
	task automatic stop_test;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tally(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (!ok)
		begin
			fails++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
		tally(got === exp, got, exp);
	endtask

	task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
		tally(got === exp, {30'h0, got}, {30'h0, exp});
	endtask

	task automatic cmpFlag(input logic got, input logic exp);
		tally(got === exp, {31'h0, got}, {31'h0, exp});
	endtask

	// ------------------------------------------------
	// bus master; entered just after a rising edge, leaves one edge later
	// so no strobe is lowered and raised in the same time step
	// ------------------------------------------------
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready) && n < 100);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 100)
			fails++;
		@(posedge sys_clk);
	endtask

	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
			if (arvalid && arready)
			begin
				arvalid <= 1'b0;
				acc = cyc;
			end
		end
		while (!(rvalid && rready) && n < 100);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 100)
			fails++;
		@(posedge sys_clk);
	endtask

	// watchdog; the longest span below is a few thousand cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		repeat (5) @(posedge sys_clk);
		cmpFlag(awready, 1'b1);
		cmpFlag(wready, 1'b1);
		cmpFlag(arready, 1'b1);
		cmpFlag(bvalid, 1'b0);
		cmpFlag(rvalid, 1'b0);
		cmpFlag(irq, 1'b0);
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axiRead(8'h00, c1, rs);
		cmpWord(c1, qt_pkg::LOAD_RST);
		axiRead(8'h08, c1, rs);
		cmpWord(c1, 32'h0);
		// table of plain accesses: map, access kinds, refused places
		foreach (rows[i])
		begin
			axiWrite(rows[i].wa, rows[i].wd, rs);
			cmpResp(rs, rows[i].be);
			axiRead(rows[i].ra, c1, rs);
			cmpResp(rs, rows[i].rr);
			if (rows[i].rr === OK)
				cmpWord(c1, rows[i].re);
		end
		// timer 0: the drop over a whole number of prescale periods is exact
		for (int p = 0; p < 3; p++)
		begin
			axiWrite(8'h08, {28'h0, pre[p], 2'h1}, rs);
			axiRead(8'h04, c1, rs);
			a1 = acc;
			repeat (10 * div[p] - 3) @(posedge sys_clk);
			axiRead(8'h04, c2, rs);
			cmpWord(c1 - c2, 32'((acc - a1) / div[p]));
		end
		// timer 2: free running from 3, wraps, flag stays until cleared
		axiWrite(8'h20, 32'h3, rs);
		axiWrite(8'h28, 32'h1, rs);
		repeat (20) @(posedge sys_clk);
		axiRead(8'h24, c1, rs);
		cmpWord({8'h0, c1[31:8]}, 32'h00FFFFFF);
		axiRead(8'h40, c1, rs);
		cmpWord(c1, 32'h4);
		cmpFlag(irq, 1'b0);
		repeat (40) @(posedge sys_clk);
		axiRead(8'h40, c1, rs);
		cmpWord(c1, 32'h4);
		axiWrite(8'h44, 32'h4, rs);
		cmpFlag(irq, 1'b1);
		axiWrite(8'h40, 32'h4, rs);
		axiRead(8'h40, c1, rs);
		cmpWord(c1, 32'h0);
		cmpFlag(irq, 1'b0);
		// timer 3: periodic from 9, period of ten ticks
		axiWrite(8'h30, 32'h9, rs);
		axiWrite(8'h38, 32'h3, rs);
		axiRead(8'h34, c1, rs);
		repeat (17) @(posedge sys_clk);
		axiRead(8'h34, c2, rs);
		cmpWord(c2, c1);
		cmpFlag(c2 <= 32'h9, 1'b1);
		axiRead(8'h40, c1, rs);
		cmpWord(c1, 32'h8);
		cmpFlag(irq, 1'b0);
		// restart while running
		axiWrite(8'h30, 32'h1000, rs);
		axiRead(8'h34, c1, rs);
		cmpFlag(c1 > 32'hFF0 && c1 <= 32'h1000, 1'b1);
		axiRead(8'h14, c1, rs);
		cmpWord(c1, 32'hCAFE0001);
		// partial strobes merge only the low half into timer 1's load word
		wstrb <= 4'h3;
		axiWrite(8'h10, 32'h1234BEEF, rs);
		wstrb <= 4'hF;
		cmpResp(rs, OK);
		axiRead(8'h10, c1, rs);
		cmpWord(c1, 32'hCAFEBEEF);
		// second reset in mid-run clears flags and counts
		axiWrite(8'h44, 32'h8, rs);
		cmpFlag(irq, 1'b1);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		cmpFlag(irq, 1'b0);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		axiRead(8'h40, c1, rs);
		cmpWord(c1, {28'h0000000, qt_pkg::STATUS_RST});
		axiRead(8'h34, c1, rs);
		cmpWord(c1, qt_pkg::COUNT_RST);
		stop_test();
	end
endmodule
